/* File: common/smfp_pkg.sv */
// package with the field packer constants and register map
package smfp_pkg;
  localparam int unsigned CODE_W = 4;
  localparam int unsigned VAL_W = 32;
  localparam int unsigned IO_W = 16;
  localparam int unsigned OPT_N = 8;
  localparam int unsigned OPT_SEL_W = 3;
  localparam int unsigned CONN_N = 8;
  localparam int unsigned CONN_SEL_W = 3;
  // selection byte layout
  localparam int unsigned SEL_LO_LSB = 0;
  localparam int unsigned SEL_HI_LSB = 4;
  // monitor codes
  localparam logic [3:0] MC_FILT_POS = 4'h0;
  localparam logic [3:0] MC_CMD_POS = 4'h1;
  localparam logic [3:0] MC_FOLLOW_ERR = 4'h2;
  localparam logic [3:0] MC_FB_POS = 4'h3;
  localparam logic [3:0] MC_LATCH_POS = 4'h4;
  localparam logic [3:0] MC_PREFILT_POS = 4'h5;
  localparam logic [3:0] MC_TARGET_POS = 4'h6;
  localparam logic [3:0] MC_FB_VEL = 4'h8;
  localparam logic [3:0] MC_CMD_VEL = 4'h9;
  localparam logic [3:0] MC_TARGET_VEL = 4'ha;
  localparam logic [3:0] MC_TORQUE = 4'hb;
  localparam logic [3:0] MC_OPT_ONE = 4'he;
  localparam logic [3:0] MC_OPT_TWO = 4'hf;
  // snapshot bit positions
  localparam int unsigned IO_FWD = 0;
  localparam int unsigned IO_REV = 1;
  localparam int unsigned IO_HOME = 2;
  localparam int unsigned IO_ENC_A = 3;
  localparam int unsigned IO_ENC_B = 4;
  localparam int unsigned IO_ENC_Z = 5;
  localparam int unsigned IO_LATCH1 = 6;
  localparam int unsigned IO_LATCH2 = 7;
  localparam int unsigned IO_LATCH3 = 8;
  localparam int unsigned IO_BRAKE = 9;
  localparam int unsigned IO_STO = 10;
  localparam int unsigned IO_RSVD = 11;
  localparam int unsigned IO_GEN_LSB = 12;
  // apb register byte offsets
  localparam logic [7:0] REG_OPT_ONE = 8'h00;
  localparam logic [7:0] REG_OPT_TWO = 8'h04;
  localparam logic [7:0] REG_GEN_SEL = 8'h08;
  localparam logic [7:0] REG_SEL_STAT = 8'h0c;
  localparam logic [7:0] REG_IO_STAT = 8'h10;
  // reset values
  localparam logic [2:0] OPT_RST = 3'h0;
  localparam logic [15:0] GEN_SEL_RST = 16'h3210;
  localparam logic [7:0] SEL_RST = 8'h00;
endpackage : smfp_pkg

/* File: src/smfp_packer.sv */
// servo monitor field packer with apb configuration slave
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
// How it works
// - slot one and two codes come from main command byte thirteen
// - slot three and four codes come from subcommand byte nineteen
// - low nibble selects the odd slot, high nibble the even slot
// - each slot carries the quantity named by its code
// - codes 0 to 3 report filtered, commanded, error and feedback positions
// - codes 4 to 6 report latched, pre-filter and target positions
// - codes 8 to a report feedback, commanded and target velocity
// - code b reports torque reference, scaled upstream by control mode
// - codes e and f report option sources picked by two parameters
// - a 16-bit i/o snapshot goes with every response
// - bits 0..2 are forward inhibit, reverse inhibit, homing switch
// - bits 3..5 are encoder a, b and index channels
// - bits 6..8 are the three latch triggers
// - bit 9 is brake locked, bit 10 is or of safety inputs
// - bit 11 reads zero, bits 12..15 are parameter-selected connector inputs
module smfp_packer (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] main_sel_byte_i,
  input wire logic [7:0] sub_sel_byte_i,
  input wire logic sub_valid_i,
  input wire logic sample_i,
  input wire logic [smfp_pkg::VAL_W-1:0] filtered_coord_i,
  input wire logic [smfp_pkg::VAL_W-1:0] cmd_coord_i,
  input wire logic [smfp_pkg::VAL_W-1:0] following_error_i,
  input wire logic [smfp_pkg::VAL_W-1:0] feedback_coord_i,
  input wire logic [smfp_pkg::VAL_W-1:0] latched_feedback_coord_i,
  input wire logic [smfp_pkg::VAL_W-1:0] cmd_coord_before_filter_i,
  input wire logic [smfp_pkg::VAL_W-1:0] target_coord_i,
  input wire logic [smfp_pkg::VAL_W-1:0] feedback_velocity_i,
  input wire logic [smfp_pkg::VAL_W-1:0] commanded_velocity_i,
  input wire logic [smfp_pkg::VAL_W-1:0] target_velocity_i,
  input wire logic [smfp_pkg::VAL_W-1:0] torque_reference_i,
  input wire logic [smfp_pkg::OPT_N*smfp_pkg::VAL_W-1:0] option_source_i,
  input wire logic forward_travel_inhibit_i,
  input wire logic reverse_travel_inhibit_i,
  input wire logic homing_slowdown_switch_i,
  input wire logic encoder_channel_a_i,
  input wire logic encoder_channel_b_i,
  input wire logic encoder_index_channel_i,
  input wire logic latch_trigger_one_i,
  input wire logic latch_trigger_two_i,
  input wire logic latch_trigger_three_i,
  input wire logic holding_brake_state_i,
  input wire logic safety_input_one_i,
  input wire logic safety_input_two_i,
  input wire logic [smfp_pkg::CONN_N-1:0] io_connector_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic [smfp_pkg::VAL_W-1:0] monitor_one_o,
  output logic [smfp_pkg::VAL_W-1:0] monitor_two_o,
  output logic [smfp_pkg::VAL_W-1:0] monitor_three_o,
  output logic [smfp_pkg::VAL_W-1:0] monitor_four_o,
  output logic [smfp_pkg::IO_W-1:0] input_output_snapshot_o,
  output logic fields_valid_o
);
  import smfp_pkg::*;

  logic [OPT_SEL_W-1:0] option_monitor_one_param_r;
  logic [OPT_SEL_W-1:0] option_monitor_two_param_r;
  logic [15:0] general_input_select_param_r;
  logic [7:0] main_sel_r;
  logic [7:0] sub_sel_r;
  logic [IO_W-1:0] snap_nxt;
  logic [CODE_W-1:0] monitor_code_select [4];
  logic setup_w;
  logic access_w;
  logic hit_w;

  // option source picked by a parameter
  function automatic logic [VAL_W-1:0] opt_pick(input logic [OPT_SEL_W-1:0] idx);
    opt_pick = option_source_i[idx*VAL_W +: VAL_W];
  endfunction : opt_pick

  // quantity named by one monitor code
  function automatic logic [VAL_W-1:0] mon_pick(input logic [CODE_W-1:0] code);
    unique case (code)
      MC_FILT_POS: mon_pick = filtered_coord_i;
      MC_CMD_POS: mon_pick = cmd_coord_i;
      MC_FOLLOW_ERR: mon_pick = following_error_i;
      MC_FB_POS: mon_pick = feedback_coord_i;
      MC_LATCH_POS: mon_pick = latched_feedback_coord_i;
      MC_PREFILT_POS: mon_pick = cmd_coord_before_filter_i;
      MC_TARGET_POS: mon_pick = target_coord_i;
      MC_FB_VEL: mon_pick = feedback_velocity_i;
      MC_CMD_VEL: mon_pick = commanded_velocity_i;
      MC_TARGET_VEL: mon_pick = target_velocity_i;
      MC_TORQUE: mon_pick = torque_reference_i;
      MC_OPT_ONE: mon_pick = opt_pick(option_monitor_one_param_r);
      MC_OPT_TWO: mon_pick = opt_pick(option_monitor_two_param_r);
      default: mon_pick = '0;
    endcase
  endfunction : mon_pick

  // connector input picked by one nibble of the select parameter
  function automatic logic gen_pick(input int unsigned n);
    gen_pick = io_connector_i[general_input_select_param_r[n*4 +: CONN_SEL_W]];
  endfunction : gen_pick

  // slot codes split from the two selection bytes
  always_comb begin
    monitor_code_select[0] = main_sel_byte_i[SEL_LO_LSB +: CODE_W];
    monitor_code_select[1] = main_sel_byte_i[SEL_HI_LSB +: CODE_W];
    if (sub_valid_i) begin
      monitor_code_select[2] = sub_sel_byte_i[SEL_LO_LSB +: CODE_W];
      monitor_code_select[3] = sub_sel_byte_i[SEL_HI_LSB +: CODE_W];
    end else begin
      monitor_code_select[2] = sub_sel_r[SEL_LO_LSB +: CODE_W];
      monitor_code_select[3] = sub_sel_r[SEL_HI_LSB +: CODE_W];
    end
  end

  // i/o snapshot assembly
  always_comb begin
    snap_nxt = '0;
    snap_nxt[IO_FWD] = forward_travel_inhibit_i;
    snap_nxt[IO_REV] = reverse_travel_inhibit_i;
    snap_nxt[IO_HOME] = homing_slowdown_switch_i;
    snap_nxt[IO_ENC_A] = encoder_channel_a_i;
    snap_nxt[IO_ENC_B] = encoder_channel_b_i;
    snap_nxt[IO_ENC_Z] = encoder_index_channel_i;
    snap_nxt[IO_LATCH1] = latch_trigger_one_i;
    snap_nxt[IO_LATCH2] = latch_trigger_two_i;
    snap_nxt[IO_LATCH3] = latch_trigger_three_i;
    snap_nxt[IO_BRAKE] = holding_brake_state_i;
    snap_nxt[IO_STO] = safety_input_one_i | safety_input_two_i;
    snap_nxt[IO_RSVD] = 1'b0;
    for (int unsigned n = 0; n < 4; n++) begin
      snap_nxt[IO_GEN_LSB + n] = gen_pick(n);
    end
  end

  // slots and snapshot captured together on the sample strobe
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      monitor_one_o <= '0;
      monitor_two_o <= '0;
      monitor_three_o <= '0;
      monitor_four_o <= '0;
      input_output_snapshot_o <= '0;
    end else if (sample_i) begin
      monitor_one_o <= mon_pick(monitor_code_select[0]);
      monitor_two_o <= mon_pick(monitor_code_select[1]);
      monitor_three_o <= mon_pick(monitor_code_select[2]);
      monitor_four_o <= mon_pick(monitor_code_select[3]);
      input_output_snapshot_o <= snap_nxt;
    end
  end

  // one-cycle mark that fresh fields stand on the outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      fields_valid_o <= 1'b0;
    end else begin
      fields_valid_o <= sample_i;
    end
  end

  // last selection bytes seen, kept for readback and slot reuse
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      main_sel_r <= SEL_RST;
      sub_sel_r <= SEL_RST;
    end else if (sample_i) begin
      main_sel_r <= main_sel_byte_i;
      if (sub_valid_i) begin
        sub_sel_r <= sub_sel_byte_i;
      end
    end
  end

  // apb phases
  assign setup_w = psel_i & ~penable_i;
  assign access_w = psel_i & penable_i & pready_o;
  assign hit_w = (paddr_i == REG_OPT_ONE) || (paddr_i == REG_OPT_TWO)
      || (paddr_i == REG_GEN_SEL) || (paddr_i == REG_SEL_STAT)
      || (paddr_i == REG_IO_STAT);

  // apb answer: ready one cycle after setup, data and error with it
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= '0;
    end else if (setup_w) begin
      pready_o <= 1'b1;
      pslverr_o <= ~hit_w;
      prdata_o <= '0;
      if (!pwrite_i) begin
        unique case (paddr_i)
          REG_OPT_ONE: prdata_o[OPT_SEL_W-1:0] <= option_monitor_one_param_r;
          REG_OPT_TWO: prdata_o[OPT_SEL_W-1:0] <= option_monitor_two_param_r;
          REG_GEN_SEL: prdata_o[15:0] <= general_input_select_param_r;
          REG_SEL_STAT: prdata_o[15:0] <= {sub_sel_r, main_sel_r};
          REG_IO_STAT: prdata_o[IO_W-1:0] <= input_output_snapshot_o;
          default: prdata_o <= '0;
        endcase
      end
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // configuration parameters written in the access phase
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      option_monitor_one_param_r <= OPT_RST;
      option_monitor_two_param_r <= OPT_RST;
      general_input_select_param_r <= GEN_SEL_RST;
    end else if (access_w && pwrite_i) begin
      if (paddr_i == REG_OPT_ONE) begin
        option_monitor_one_param_r <= pwdata_i[OPT_SEL_W-1:0];
      end
      if (paddr_i == REG_OPT_TWO) begin
        option_monitor_two_param_r <= pwdata_i[OPT_SEL_W-1:0];
      end
      if (paddr_i == REG_GEN_SEL) begin
        general_input_select_param_r <= pwdata_i[15:0];
      end
    end
  end

  // checks next to the logic
  a_slot_one_code: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i && main_sel_byte_i[3:0] == MC_FB_VEL
      |=> monitor_one_o == $past(feedback_velocity_i))
    else $error("slot one value does not match its code");
  a_unassigned_zero: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i && main_sel_byte_i[7:4] == 4'h7 |=> monitor_two_o == '0)
    else $error("unassigned code gave a nonzero value");
  a_sub_slot_three: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i && sub_valid_i && sub_sel_byte_i[3:0] == MC_FB_POS
      |=> monitor_three_o == $past(feedback_coord_i))
    else $error("slot three not fed from subcommand byte");
  a_torque_slot: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i && sub_valid_i && sub_sel_byte_i[7:4] == MC_TORQUE
      |=> monitor_four_o == $past(torque_reference_i))
    else $error("slot four torque mismatch");
  a_reserved_bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    input_output_snapshot_o[IO_RSVD] == 1'b0)
    else $error("reserved snapshot bit set");
  a_stop_or: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i |=> input_output_snapshot_o[IO_STO]
      == $past(safety_input_one_i | safety_input_two_i))
    else $error("forced stop bit not or of safety inputs");
  a_fields_hold: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !sample_i |=> $stable(monitor_one_o) && $stable(input_output_snapshot_o))
    else $error("fields changed without a sample");
  a_home_bit: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i |=> input_output_snapshot_o[IO_HOME] == $past(homing_slowdown_switch_i))
    else $error("homing switch bit mismatch");
  a_latch_bits: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    sample_i |=> input_output_snapshot_o[IO_LATCH3:IO_LATCH1] == $past({latch_trigger_three_i,
      latch_trigger_two_i, latch_trigger_one_i}))
    else $error("latch trigger bits mismatch");
endmodule : smfp_packer
`default_nettype wire

/* File: tb/smfp_host_model.sv */
// host controller model driving selection bytes and capture strobe
`timescale 1ns/1ns
`default_nettype none
module smfp_host_model (
  input wire logic clk_sys_i,
  output var logic [7:0] main_sel_byte_o,
  output var logic [7:0] sub_sel_byte_o,
  output var logic sub_valid_o,
  output var logic sample_o
);
  // idle values at time zero
  initial begin
    main_sel_byte_o = 8'h00;
    sub_sel_byte_o = 8'h00;
    sub_valid_o = 1'b0;
    sample_o = 1'b0;
  end
  // one frame, bytes scrambled once the capture edge has passed
  task automatic frame(input logic [7:0] m, input logic [7:0] s, input logic v);
    @(posedge clk_sys_i);
    main_sel_byte_o <= m;
    sub_sel_byte_o <= s;
    sub_valid_o <= v;
    sample_o <= 1'b1;
    @(posedge clk_sys_i);
    main_sel_byte_o <= ~m;
    sub_sel_byte_o <= ~s;
    sub_valid_o <= 1'b0;
    sample_o <= 1'b0;
  endtask : frame
endmodule : smfp_host_model
`default_nettype wire

/* File: tb/tb_servo_monitor_field_packer.sv */
// self-checking bench for the monitor field packer
`timescale 1ns/1ns
`default_nettype none
module tb_servo_monitor_field_packer;
  import smfp_pkg::*;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] m_b, s_b, paddr = 8'h00, conn = 8'h00;
  logic sv, smp, fv, er, pready, following_error, psel = 0, pen = 0, pwr = 0;
  logic [31:0] q [16];
  logic [31:0] mon [4];
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [255:0] opt_src;
  logic [11:0] pins = 12'h000;
  logic [15:0] snap;
  int failures = 0;
  int check_count = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  smfp_host_model host_u (.clk_sys_i(clk_sys_i), .main_sel_byte_o(m_b),
    .sub_sel_byte_o(s_b), .sub_valid_o(sv), .sample_o(smp));
  smfp_packer dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .main_sel_byte_i(m_b),
    .sub_sel_byte_i(s_b), .sub_valid_i(sv), .sample_i(smp), .filtered_coord_i(q[0]),
    .cmd_coord_i(q[1]), .following_error_i(q[2]), .feedback_coord_i(q[3]),
    .latched_feedback_coord_i(q[4]), .cmd_coord_before_filter_i(q[5]),
    .target_coord_i(q[6]), .feedback_velocity_i(q[8]), .commanded_velocity_i(q[9]),
    .target_velocity_i(q[10]), .torque_reference_i(q[11]), .option_source_i(opt_src),
    .forward_travel_inhibit_i(pins[0]), .reverse_travel_inhibit_i(pins[1]),
    .homing_slowdown_switch_i(pins[2]), .encoder_channel_a_i(pins[3]),
    .encoder_channel_b_i(pins[4]), .encoder_index_channel_i(pins[5]),
    .latch_trigger_one_i(pins[6]), .latch_trigger_two_i(pins[7]),
    .latch_trigger_three_i(pins[8]), .holding_brake_state_i(pins[9]),
    .safety_input_one_i(pins[10]), .safety_input_two_i(pins[11]), .io_connector_i(conn),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(following_error), .monitor_one_o(mon[0]),
    .monitor_two_o(mon[1]), .monitor_three_o(mon[2]), .monitor_four_o(mon[3]),
    .input_output_snapshot_o(snap), .fields_valid_o(fv));
  // expected slot value for a code and option selections
  function automatic logic [31:0] ev(input logic [3:0] c, input int o1, input int o2);
    case (c)
      MC_OPT_ONE: ev = opt_src[o1*32 +: 32];
      MC_OPT_TWO: ev = opt_src[o2*32 +: 32];
      4'h7, 4'hc, 4'hd: ev = 32'h0;
      default: ev = q[c];
    endcase
  endfunction : ev
  // expected snapshot for a general input selection
  function automatic logic [15:0] ex_io(input logic [15:0] g);
    ex_io = {conn[g[14:12]], conn[g[10:8]], conn[g[6:4]], conn[g[2:0]], 1'b0,
      pins[10] | pins[11], pins[9:0]};
  endfunction : ex_io
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: %s got %h want %h", $time, s, g, e);
    end
  endtask : chk
  // one apb transfer, waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    pen <= 1'b1;
    n = 0;
    // pready, data and error are read as they stood at the access edge
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "pready timeout");
      end_sim();
    end
    rd = prdata;
    er = following_error;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic take(input logic [7:0] m, input logic [7:0] s, input logic v);
    host_u.frame(m, s, v);
    #1;
    chk({31'h0, fv}, 32'h1, "valid pulse");
  endtask : take
  task automatic t_codes();
    int c;
    logic [3:0] k;
    for (c = 0; c < 16; c++) begin
      k = 4'(c);
      take({k + 4'h1, k}, {k + 4'h2, k + 4'h3}, 1'b1);
      chk(mon[0], ev(k, 0, 0), "slot one");
      chk(mon[1], ev(k + 4'h1, 0, 0), "slot two");
      chk(mon[2], ev(k + 4'h3, 0, 0), "slot three");
      chk(mon[3], ev(k + 4'h2, 0, 0), "slot four");
    end
    apb(1'b0, REG_SEL_STAT, 32'h0);
    chk(rd, 32'h0000120f, "codes readback");
    take(8'h10, 8'h99, 1'b0);
    chk(mon[2], ev(4'h2, 0, 0), "kept slot three");
    chk(mon[3], ev(4'h1, 0, 0), "kept slot four");
    @(posedge clk_sys_i);
    #1;
    chk({31'h0, fv}, 32'h0, "valid drop");
    $display("test codes done");
  endtask : t_codes
  task automatic t_opt();
    apb(1'b0, REG_OPT_ONE, 32'h0);
    chk(rd, 32'h0, "opt one reset");
    apb(1'b1, REG_OPT_ONE, 32'h5);
    apb(1'b1, REG_OPT_TWO, 32'h3);
    apb(1'b0, REG_OPT_TWO, 32'h0);
    chk(rd, 32'h3, "opt two readback");
    take(8'hfe, 8'hef, 1'b1);
    chk(mon[0], ev(4'he, 5, 3), "opt slot one");
    chk(mon[1], ev(4'hf, 5, 3), "opt slot two");
    chk(mon[2], ev(4'hf, 5, 3), "opt slot three");
    chk(mon[3], ev(4'he, 5, 3), "opt slot four");
    apb(1'b0, 8'h40, 32'h0);
    chk({30'h0, er, 1'b0} | rd, 32'h2, "unmapped read");
    $display("test options done");
  endtask : t_opt
  task automatic t_io();
    int i, j;
    logic [15:0] g;
    g = GEN_SEL_RST;
    apb(1'b0, REG_GEN_SEL, 32'h0);
    chk(rd, 32'h00003210, "select reset");
    for (j = 0; j < 2; j++) begin
      for (i = 0; i < 20; i++) begin
        @(posedge clk_sys_i);
        pins <= (i < 12) ? 12'(1 << i) : 12'h000;
        conn <= (i < 12) ? 8'h00 : 8'(1 << (i - 12));
        take(8'h00, 8'h00, 1'b1);
        chk({16'h0, snap}, {16'h0, ex_io(g)}, "snapshot");
      end
      g = 16'h4567;
      apb(1'b1, REG_GEN_SEL, 32'h4567);
    end
    apb(1'b1, REG_IO_STAT, 32'hffff);
    apb(1'b0, REG_IO_STAT, 32'h0);
    chk(rd, {16'h0, ex_io(g)}, "snapshot reg");
    @(posedge clk_sys_i);
    pins <= 12'hfff;
    conn <= 8'hff;
    repeat (2) @(posedge clk_sys_i);
    #1;
    chk({16'h0, snap}, 32'h00001000, "snapshot held");
    $display("test io done");
  endtask : t_io
  // main sequence
  initial begin
    for (int k = 0; k < 16; k++) q[k] = 32'(32'h11111111 * (k + 1));
    for (int k = 0; k < 8; k++) opt_src[k*32 +: 32] = 32'h0e000000 + 32'(k);
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(mon[0] | {16'h0, snap}, 32'h0, "reset outputs");
    t_codes();
    t_opt();
    t_io();
    end_sim();
  end
endmodule : tb_servo_monitor_field_packer
`default_nettype wire
